/* hw/pwm_gate_pkg.sv */
package pwm_gate_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_LINES  = 8;
	localparam int TIME_W     = 16;
	localparam int ADDR_W     = 16;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_SOFTSTART = 16'hFE68;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_A_LL = 16'hFE69;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_B_LL = 16'hFE6A;
	localparam logic [ADDR_W-1:0] ADDR_STATUS    = 16'hFE6C;

	// ****************************************
	// Soft-start variation field positions
	// ****************************************
	localparam int BIT_EVEN_SEL    = 0;
	localparam int BIT_ODD_SEL     = 1;
	localparam int BIT_LINE2_VAR   = 2;
	localparam int BIT_GLOBAL_VAR  = 3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_SOFTSTART = 8'h00;
	localparam logic [7:0] RST_LL_DIS    = 8'h00;

	// ****************************************
	// Bus answers and status layout
	// ****************************************
	localparam logic [1:0] RESP_OKAY          = 2'h0;
	localparam logic [1:0] RESP_SLVERR        = 2'h2;
	localparam int         SOFTSTART_BITS     = 4;
	localparam int         BIT_STAT_SOFTSTART = 8;
	localparam int         BIT_STAT_A_LL      = 9;
	localparam int         BIT_STAT_B_LL      = 10;

	// Per-line edge timing, counts of the PWM engine timebase
	typedef struct packed {
		logic [TIME_W-1:0] rise;
		logic [TIME_W-1:0] fall;
	} edge_times_t;

	typedef enum logic [1:0] {
		SRC_LINE1,
		SRC_LINE2,
		SRC_LINE3
	} var_source_t;

endpackage : pwm_gate_pkg

/* hw/pwm_softstart_lightload_gate.sv */
`timescale 1ns/1ps
module pwm_softstart_lightload_gate
	import pwm_gate_pkg::*;
#(
	parameter int LINES = pwm_gate_pkg::NUM_LINES
) (
	// Clock and reset
	input  wire logic                                  clock,
	input  wire logic                                  nrst,
	// Avalon-MM slave
	input  wire logic [pwm_gate_pkg::ADDR_W-1:0]       address,
	input  wire logic                                  read,
	input  wire logic                                  write,
	input  wire logic [31:0]                           writedata,
	input  wire logic [3:0]                            byteenable,
	output logic      [31:0]                           readdata,
	output logic                                       waitrequest,
	output logic      [1:0]                            response,
	// PWM engine side
	input  wire logic [LINES-1:0]                      pwm_in,
	input  wire pwm_gate_pkg::edge_times_t [LINES-1:0] line_edges,
	input  wire logic [pwm_gate_pkg::TIME_W-1:0]       switch_period,
	input  wire logic                                  chan_c_softstart,
	input  wire logic                                  chan_a_lightload,
	input  wire logic                                  chan_b_lightload,
	// Gated outputs and variation results
	output logic      [LINES-1:0]                      pwm_out,
	output logic      [pwm_gate_pkg::TIME_W-1:0]       odd_variation,
	output logic      [pwm_gate_pkg::TIME_W-1:0]       even_variation
);
	import pwm_gate_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	// Every writable register sits in byte lane 0, so LINES must equal NUM_LINES, one bit per line of a byte
	if (LINES != NUM_LINES) begin : g_lines_check
		$error("LINES must equal NUM_LINES");
	end

	// ****************************************
	// Helpers
	// ****************************************
	typedef enum {
		SEL_SOFTSTART,
		SEL_CHAN_A_LL,
		SEL_CHAN_B_LL,
		SEL_STATUS,
		SEL_NONE
	} reg_sel_t;

	// On-time variation taken from one line's own edges
	function automatic logic [TIME_W-1:0] edge_diff(input edge_times_t e);
		edge_diff = e.fall - e.rise;
	endfunction : edge_diff

	// Register picked by a bus address
	function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_SOFTSTART: decode_addr = SEL_SOFTSTART;
			ADDR_CHAN_A_LL: decode_addr = SEL_CHAN_A_LL;
			ADDR_CHAN_B_LL: decode_addr = SEL_CHAN_B_LL;
			ADDR_STATUS:    decode_addr = SEL_STATUS;
			default:        decode_addr = SEL_NONE;
		endcase
	endfunction : decode_addr

	// ****************************************
	// Bus handshake
	// ****************************************
	logic req, ack, next_ack;

	assign req         = read | write;
	// One wait cycle per access; the answer stands in the second cycle
	assign waitrequest = req & ~ack;

	always_comb begin
		next_ack = 1'h0;
		if (req && !ack)
			next_ack = 1'h1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			ack <= 1'h0;
		else
			ack <= next_ack;
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [7:0] softstart_cfg, next_softstart_cfg;
	logic [7:0] chan_a_lightload_out_disable, next_chan_a_lightload_out_disable;
	logic [7:0] chan_b_lightload_out_disable, next_chan_b_lightload_out_disable;
	logic       commit;

	// A write lands only at the edge where the master sees waitrequest low
	assign commit = write & ack & byteenable[0];

	always_comb begin
		next_softstart_cfg                = softstart_cfg;
		next_chan_a_lightload_out_disable = chan_a_lightload_out_disable;
		next_chan_b_lightload_out_disable = chan_b_lightload_out_disable;
		if (commit) begin
			case (decode_addr(address))
				SEL_SOFTSTART:
					next_softstart_cfg = 8'(writedata[SOFTSTART_BITS-1:0]);
				SEL_CHAN_A_LL:
					next_chan_a_lightload_out_disable = writedata[7:0];
				SEL_CHAN_B_LL:
					next_chan_b_lightload_out_disable = writedata[7:0];
				default: begin
					// Status and unmapped addresses ignore writes
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			softstart_cfg                <= RST_SOFTSTART;
			chan_a_lightload_out_disable <= RST_LL_DIS;
			chan_b_lightload_out_disable <= RST_LL_DIS;
		end else begin
			softstart_cfg                <= next_softstart_cfg;
			chan_a_lightload_out_disable <= next_chan_a_lightload_out_disable;
			chan_b_lightload_out_disable <= next_chan_b_lightload_out_disable;
		end
	end

	// ****************************************
	// Read answer
	// ****************************************
	logic [31:0] next_readdata;
	logic [1:0]  next_response;

	// Captured in the wait cycle and held until the next access
	always_comb begin
		next_readdata = readdata;
		next_response = response;
		if (req && !ack) begin
			next_readdata = 32'h0000_0000;
			next_response = RESP_OKAY;
			case (decode_addr(address))
				SEL_SOFTSTART:
					next_readdata[7:0] = softstart_cfg;
				SEL_CHAN_A_LL:
					next_readdata[7:0] = chan_a_lightload_out_disable;
				SEL_CHAN_B_LL:
					next_readdata[7:0] = chan_b_lightload_out_disable;
				SEL_STATUS: begin
					next_readdata[LINES-1:0]          = pwm_out;
					next_readdata[BIT_STAT_SOFTSTART] = chan_c_softstart;
					next_readdata[BIT_STAT_A_LL]      = chan_a_lightload;
					next_readdata[BIT_STAT_B_LL]      = chan_b_lightload;
				end
				default:
					next_response = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			readdata <= 32'h0000_0000;
			response <= RESP_OKAY;
		end else begin
			readdata <= next_readdata;
			response <= next_response;
		end
	end

	// ****************************************
	// Soft-start variation
	// ****************************************
	var_source_t       odd_src;
	logic [TIME_W-1:0] line2_var, line3_var, line1_var;
	logic [TIME_W-1:0] next_odd_variation, next_even_variation;

	always_comb begin
		line1_var = edge_diff(line_edges[0]);
		line3_var = edge_diff(line_edges[2]);
		if (softstart_cfg[BIT_LINE2_VAR])
			line2_var = switch_period - line_edges[1].rise;
		else
			line2_var = edge_diff(line_edges[1]);
		if (softstart_cfg[BIT_GLOBAL_VAR])
			odd_src = SRC_LINE2;
		else if (softstart_cfg[BIT_ODD_SEL])
			odd_src = SRC_LINE3;
		else
			odd_src = SRC_LINE1;
		next_odd_variation  = odd_variation;
		next_even_variation = even_variation;
		if (chan_c_softstart) begin
			case (odd_src)
				SRC_LINE1: next_odd_variation = line1_var;
				SRC_LINE3: next_odd_variation = line3_var;
				SRC_LINE2: next_odd_variation = line2_var;
				default:   next_odd_variation = line1_var;
			endcase
			// Even group always follows line 2, whatever the even select and global bits hold
			next_even_variation = line2_var;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			odd_variation  <= '0;
			even_variation <= '0;
		end else begin
			odd_variation  <= next_odd_variation;
			even_variation <= next_even_variation;
		end
	end

	// ****************************************
	// Light-load blanking
	// ****************************************
	logic [LINES-1:0] blank_mask, next_pwm_out;

	always_comb begin
		blank_mask   = ({LINES{chan_a_lightload}} & chan_a_lightload_out_disable) |
			({LINES{chan_b_lightload}} & chan_b_lightload_out_disable);
		next_pwm_out = pwm_in & ~blank_mask;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			pwm_out <= '0;
		else
			pwm_out <= next_pwm_out;
	end

endmodule : pwm_softstart_lightload_gate

/* tb/gate_stage.sv */
`timescale 1ns/1ps
module gate_stage (
	input  wire logic       clock,
	input  wire logic [7:0] gate_in,
	output logic      [7:0] switch_on
);
	// Switches follow their gate drive one clock later
	always_ff @(posedge clock) switch_on <= gate_in;
endmodule : gate_stage

/* tb/pwm_gate_checker.sv */
`timescale 1ns/1ps
module pwm_gate_checker
	import pwm_gate_pkg::*;
#(parameter int LINES = 8) (
	input wire logic               clock, nrst, read, write, waitrequest, chan_c_softstart,
	input wire logic               chan_a_lightload, chan_b_lightload,
	input wire logic [15:0]        address, switch_period, odd_variation, even_variation,
	input wire logic [31:0]        writedata, readdata,
	input wire logic [3:0]         byteenable,
	input wire logic [LINES-1:0]   pwm_in, pwm_out,
	input wire edge_times_t [LINES-1:0] line_edges
);
	logic [7:0] cfg;
	logic [LINES-1:0] dis_a, dis_b;
	wire take = write & ~waitrequest & byteenable[0];
	wire [15:0] v2 = cfg[2] ? switch_period - line_edges[1].rise
		: line_edges[1].fall - line_edges[1].rise;
	wire [15:0] v1 = cfg[1] ? line_edges[2].fall - line_edges[2].rise
		: line_edges[0].fall - line_edges[0].rise;
	wire [LINES-1:0] gated = pwm_in & ~(({LINES{chan_a_lightload}} & dis_a)
		| ({LINES{chan_b_lightload}} & dis_b));
	// Shadow copies of the configuration registers
	always_ff @(posedge clock or negedge nrst)
		if (!nrst) {cfg, dis_a, dis_b} <= '0;
		else if (take) begin
			if (address == ADDR_SOFTSTART) cfg <= writedata[7:0];
			if (address == ADDR_CHAN_A_LL) dis_a <= writedata[LINES-1:0];
			if (address == ADDR_CHAN_B_LL) dis_b <= writedata[LINES-1:0];
		end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	property p_line2; chan_c_softstart |=> even_variation == $past(v2); endproperty
	a_line2: assert property (p_line2) else $error("line 2 variation");
	property p_odd; chan_c_softstart && !cfg[3] |=> odd_variation == $past(v1); endproperty
	a_odd: assert property (p_odd) else $error("odd variation");
	property p_even; chan_c_softstart && !cfg[3] && !cfg[0] |=> even_variation == $past(v2);
	endproperty
	a_even: assert property (p_even) else $error("even variation");
	property p_glob; chan_c_softstart && cfg[3] |=> odd_variation == $past(v2); endproperty
	a_glob: assert property (p_glob) else $error("global variation");
	property p_dis_a; chan_a_lightload |=> (pwm_out & $past(dis_a)) == '0; endproperty
	a_dis_a: assert property (p_dis_a) else $error("line not blanked A");
	property p_dis_b; chan_b_lightload |=> (pwm_out & $past(dis_b)) == '0; endproperty
	a_dis_b: assert property (p_dis_b) else $error("line not blanked B");
	property p_gate; 1'b1 |=> pwm_out == $past(gated); endproperty
	a_gate: assert property (p_gate) else $error("gated output wrong");
	sequence s_wait; (read || write) && waitrequest; endsequence
	sequence s_answered; !waitrequest; endsequence
	property p_answer; s_wait |=> s_answered; endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_rd_a;
		read && !waitrequest && address == ADDR_CHAN_A_LL |-> readdata[7:0] == dis_a;
	endproperty
	a_rd_a: assert property (p_rd_a) else $error("light-load A readback wrong");
endmodule : pwm_gate_checker
bind pwm_softstart_lightload_gate pwm_gate_checker #(.LINES(LINES)) chk_u (.clock(clock),
	.nrst(nrst), .read(read), .readdata(readdata),
	.write(write), .waitrequest(waitrequest), .address(address),
	.writedata(writedata), .byteenable(byteenable), .switch_period(switch_period),
	.chan_c_softstart(chan_c_softstart), .chan_a_lightload(chan_a_lightload),
	.chan_b_lightload(chan_b_lightload), .pwm_in(pwm_in), .pwm_out(pwm_out),
	.line_edges(line_edges), .odd_variation(odd_variation), .even_variation(even_variation));

/* tb/tb_pwm_softstart_lightload_gate.sv */
`timescale 1ns/1ps
module tb_pwm_softstart_lightload_gate;
	import pwm_gate_pkg::*;
	logic clock = 0, nrst = 0, read = 0, write = 0, waitrequest;
	logic chan_c_softstart = 0, chan_a_lightload = 0, chan_b_lightload = 0;
	logic [15:0] address = '0, switch_period = 16'h00C8, odd_variation, even_variation, e2;
	logic [31:0] writedata = '0, readdata, q;
	logic [7:0] pwm_in = '0, pwm_out, gate_seen;
	logic [1:0] response;
	edge_times_t [7:0] line_edges = {160'h0, 96'h0005_0041_0014_005A_000A_0032};
	int err_count = 0, checks = 0, cyc = 0;
	pwm_softstart_lightload_gate dut_u (.clock(clock), .nrst(nrst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'h1),
		.readdata(readdata), .waitrequest(waitrequest), .response(response),
		.pwm_in(pwm_in), .line_edges(line_edges), .switch_period(switch_period),
		.chan_c_softstart(chan_c_softstart), .chan_a_lightload(chan_a_lightload),
		.chan_b_lightload(chan_b_lightload), .pwm_out(pwm_out),
		.odd_variation(odd_variation), .even_variation(even_variation));
	gate_stage stage_u (.clock(clock), .gate_in(pwm_out), .switch_on(gate_seen));
	task automatic chk(input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		writedata <= {24'h0, d};
		write <= wr;
		read <= !wr;
		do @(posedge clock); while (waitrequest !== 1'b0 && cyc < 3000);
		q = readdata;
		write <= 0;
		read <= 0;
	endtask : acc
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial forever #20 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge clock);
		nrst <= 1;
		acc(0, ADDR_CHAN_A_LL, 0);
		chk(q, 32'h0);
		acc(1, ADDR_CHAN_A_LL, 8'hA5);
		acc(0, ADDR_CHAN_A_LL, 0);
		chk(q, 32'hA5);
		acc(1, ADDR_CHAN_B_LL, 8'h3C);
		acc(0, ADDR_CHAN_B_LL, 0);
		chk(q, 32'h3C);
		acc(0, 16'hFE6B, 0);
		chk({30'h0, response}, 32'h2);
		$display("register test done");
		for (int m = 0; m < 4; m++) begin
			@(posedge clock);
			pwm_in <= 8'hDB;
			chan_a_lightload <= m[0];
			chan_b_lightload <= m[1];
			e2 = {8'h0, 8'hDB & ~((m[0] ? 8'hA5 : 8'h0) | (m[1] ? 8'h3C : 8'h0))};
			@(posedge clock);
			@(negedge clock);
			chk({24'h0, pwm_out}, {16'h0, e2});
			@(negedge clock);
			chk({24'h0, gate_seen}, {16'h0, e2});
		end
		acc(0, ADDR_STATUS, 0);
		chk(q, 32'h642);
		$display("light load test done");
		@(posedge clock);
		chan_c_softstart <= 1;
		for (int c = 0; c < 16; c++) begin
			acc(1, ADDR_SOFTSTART, 8'(c));
			repeat (2) @(posedge clock);
			@(negedge clock);
			e2 = c[2] ? 16'h00B4 : 16'h0046;
			chk({16'h0, even_variation}, {16'h0, e2});
			chk({16'h0, odd_variation}, {16'h0, c[3] ? e2 : c[1] ? 16'h003C : 16'h0028});
		end
		$display("soft start test done");
		conclude();
	end
endmodule : tb_pwm_softstart_lightload_gate
